/* common/chan_cfg_pkg.sv */
// Constants, field layouts and carrier types for one up-converter channel's
// filter control and slave update mask registers.
// Assumes a 16-bit host port and the device sample clock for all logic.
package chan_cfg_pkg;

    // ==========================================================
    // Host port
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 16;
    localparam logic [7:0]  ADDR_FILTER_CTRL = 8'h0D;
    localparam logic [7:0]  ADDR_UPDATE_MASK = 8'h0E;

    // ==========================================================
    // Filter control fields
    localparam int          FC_GAIN_PROFILE  = 15;
    localparam int          FC_CLEAR_PHASE   = 14;
    localparam int          FC_FM_IND_DIS    = 13;
    localparam int          FC_FIXED_INT     = 12;
    localparam int          FC_PHASE_HI      = 11;
    localparam int          FC_PHASE_LO      = 10;
    localparam int          FC_HALF_BAND     = 9;
    localparam int          FC_COEF_SWITCH   = 8;
    localparam int          FC_SPAN_HI       = 7;
    localparam int          FC_SPAN_LO       = 4;
    localparam int          FC_MOD_HI        = 3;
    localparam int          FC_MOD_LO        = 2;
    localparam int          FC_INTERP_HI     = 1;
    localparam int          FC_INTERP_LO     = 0;
    localparam logic [15:0] FC_RESET         = 16'h0000;

    // ==========================================================
    // Update mask fields: groups 0..4 sit at bits 6..10
    localparam int          NUM_GROUPS       = 5;
    localparam int          MASK_GROUP_LO    = 6;
    localparam int          MASK_PN          = 15;
    localparam int          GRP_CARRIER_FREQ = 0;
    localparam int          GRP_CARRIER_PH   = 1;
    localparam int          GRP_GAIN         = 2;
    localparam int          GRP_FILTER_CTRL  = 3;
    localparam int          GRP_SERIAL_CTRL  = 4;
    localparam logic [15:0] MASK_WRITABLE    = 16'h87C0;
    localparam logic [15:0] MASK_RESET       = 16'h0000;

    // ==========================================================
    // Timing and decode values
    localparam int          IMM_SYNC_CYCLES  = 4;
    localparam logic [4:0]  PHASES_4         = 5'h04;
    localparam logic [4:0]  PHASES_8         = 5'h08;
    localparam logic [4:0]  PHASES_16        = 5'h10;
    localparam logic [4:0]  PHASES_NONE      = 5'h00;

    typedef enum logic [1:0] {
        MOD_VECTOR  = 2'b00,
        MOD_FM_POST = 2'b01,
        MOD_FM_PRE  = 2'b10,
        MOD_INVALID = 2'b11
    } mod_type_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic       fm_mod_en;
        logic       fm_before_filter;
        logic       filter_before_fm;
        logic       q_filter_en;
        logic       q_fifo_en;
        logic       mod_invalid;
        logic       half_band_en;
        logic       coef_bank_sel;
        logic [4:0] span_taps;
        logic [4:0] coarse_phases;
        logic       phase_zero;
    } path_cfg_t;

endpackage

/* rtl/channel_filter_control_update_mask.sv */
// Filter control and slave update mask for one up-converter channel.
// Assumes host port strobes and update strobes are one-cycle pulses on sys_clk.
//
// How it works
// - Gain profiling set: gain slews on every transmit enable change.
// - Clear-phase set: immediate sample frequency update also clears phase.
// - FM indication disable withholds FM indication from serial block.
// - Fixed integer divider used only while its enable bit is set.
// - Phase offset field shifts NCO phase in quarter-turn steps.
// - Half-band filter bypassed at 0, the default; in path at 1.
// - Coefficient switch selects second coefficient set.
// - Modulation code: 00 vector, 01 FM post, 10 FM pre, 11 invalid.
// - FM post mode uses both I and Q shaping filters.
// - FM pre mode uses only the I shaping filter.
// - Interpolation code gives 4, 8, 16 phases; 00 zeroes phase.
// - Vector path: FIFO, shaping filter, interpolating filter.
// - FM post path: FIFO, FM modulator, shaping, interpolating filter.
// - FM pre path: FIFO, shaping, FM modulator, interpolating filter.
// - Q input FIFO unused in either Internal_freq_mod_indication.
// - Channel 0 update strobe and PN mask bit reset noise source.
// - Mask bits 10 to 6 each allow or block their slave reload.
// - Mask governs reloads on hardware or software update strobes.
// - Immediate option: writes reload directly, ignore mask, four clocks.
`timescale 1ns/1ps

module channel_filter_control_update_mask
    import chan_cfg_pkg::*;
#(
    parameter int PHASE_W = 32
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire chan_cfg_pkg::host_req_t   host_req,
    input  wire logic                      hardware_update_strobe,
    input  wire logic                      ch0_hardware_update_strobe,
    input  wire logic                      software_update_strobe,
    input  wire logic                      immediate_update_en,
    input  wire logic [chan_cfg_pkg::NUM_GROUPS-1:0] master_written,
    input  wire logic                      sample_freq_immediate_load,
    input  wire logic                      tx_enable,
    output logic [chan_cfg_pkg::DATA_W-1:0] host_rdata,
    output logic                           host_rvalid,
    output logic [chan_cfg_pkg::NUM_GROUPS-1:0] slave_reload,
    output logic                           pseudo_noise_source_reset,
    output logic                           gain_slew_start,
    output logic                           sample_phase_clear,
    output logic                           internal_freq_mod_indication,
    output logic                           fixed_int_div_en,
    output logic [PHASE_W-1:0]             nco_phase_offset,
    output chan_cfg_pkg::path_cfg_t        path_cfg
);
    import chan_cfg_pkg::*;

    // ==========================================================
    // Master registers written by the host
    logic [DATA_W-1:0] filter_ctrl;
    logic [DATA_W-1:0] update_mask;
    logic [DATA_W-1:0] filter_ctrl_active;
    logic              wr_filter;
    logic              wr_mask;

    assign wr_filter = host_req.wr && (host_req.addr == ADDR_FILTER_CTRL);
    assign wr_mask   = host_req.wr && (host_req.addr == ADDR_UPDATE_MASK);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            filter_ctrl <= FC_RESET;
        end else if (wr_filter) begin
            filter_ctrl <= host_req.wdata;
        end
    end

    // Reserved mask bits are never stored, so they cannot steer a reload
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            update_mask <= MASK_RESET;
        end else if (wr_mask) begin
            update_mask <= host_req.wdata & MASK_WRITABLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_rdata  <= '0;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd;
            if (host_req.rd && host_req.addr == ADDR_FILTER_CTRL) begin
                host_rdata <= filter_ctrl;
            end else if (host_req.rd && host_req.addr == ADDR_UPDATE_MASK) begin
                host_rdata <= update_mask;
            end else begin
                host_rdata <= '0;
            end
        end
    end

    // ==========================================================
    // Update steering
    // The immediate path waits out the synchroniser the slave side needs,
    // so a bypass load lands four clocks after the write.
    logic [NUM_GROUPS-1:0] written_now;
    logic [NUM_GROUPS-1:0] imm_pipe [IMM_SYNC_CYCLES-1];
    logic [NUM_GROUPS-1:0] next_reload;
    logic                  update_any;

    assign update_any  = hardware_update_strobe || software_update_strobe;
    assign written_now = master_written | (NUM_GROUPS'(wr_filter) << GRP_FILTER_CTRL);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int s = 0; s < IMM_SYNC_CYCLES - 1; s++) begin
                imm_pipe[s] <= '0;
            end
        end else begin
            imm_pipe[0] <= immediate_update_en ? written_now : '0;
            for (int s = 1; s < IMM_SYNC_CYCLES - 1; s++) begin
                imm_pipe[s] <= imm_pipe[s-1];
            end
        end
    end

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_reload
        assign next_reload[g] = (update_any && update_mask[MASK_GROUP_LO + g])
                              || imm_pipe[IMM_SYNC_CYCLES-2][g];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slave_reload <= '0;
        end else begin
            slave_reload <= next_reload;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pseudo_noise_source_reset <= 1'b0;
        end else begin
            pseudo_noise_source_reset <= ch0_hardware_update_strobe
                                         && update_mask[MASK_PN];
        end
    end

    // ==========================================================
    // Filter control slave: the copy the data path really runs from
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            filter_ctrl_active <= FC_RESET;
        end else if (next_reload[GRP_FILTER_CTRL]) begin
            filter_ctrl_active <= filter_ctrl;
        end
    end

    // ==========================================================
    // Decode of the active filter control word
    mod_type_t mod_type;
    logic      tx_enable_d;
    path_cfg_t next_path;

    assign mod_type = mod_type_t'(filter_ctrl_active[FC_MOD_HI:FC_MOD_LO]);

    always_comb begin
        next_path               = '0;
        next_path.half_band_en  = filter_ctrl_active[FC_HALF_BAND];
        next_path.coef_bank_sel = filter_ctrl_active[FC_COEF_SWITCH];
        // Span is trusted as programmed; values below 3 are the host's fault
        next_path.span_taps     = {1'b0, filter_ctrl_active[FC_SPAN_HI:FC_SPAN_LO]}
                                  + 5'h01;
        case (mod_type)
            MOD_VECTOR: begin
                next_path.q_filter_en = 1'b1;
                next_path.q_fifo_en   = 1'b1;
            end
            MOD_FM_POST: begin
                next_path.fm_mod_en        = 1'b1;
                next_path.fm_before_filter = 1'b1;
                next_path.q_filter_en      = 1'b1;
            end
            MOD_FM_PRE: begin
                next_path.fm_mod_en        = 1'b1;
                next_path.filter_before_fm = 1'b1;
                next_path.q_filter_en      = 1'b0;
            end
            default: begin
                next_path.mod_invalid = 1'b1;
            end
        endcase
        case (filter_ctrl_active[FC_INTERP_HI:FC_INTERP_LO])
            2'h1: next_path.coarse_phases = PHASES_4;
            2'h2: next_path.coarse_phases = PHASES_8;
            2'h3: next_path.coarse_phases = PHASES_16;
            default: begin
                next_path.coarse_phases = PHASES_NONE;
                next_path.phase_zero    = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            path_cfg <= '0;
        end else begin
            path_cfg <= next_path;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            internal_freq_mod_indication <= 1'b0;
            fixed_int_div_en             <= 1'b0;
            nco_phase_offset             <= '0;
        end else begin
            internal_freq_mod_indication <= next_path.fm_mod_en
                                            && !filter_ctrl_active[FC_FM_IND_DIS];
            fixed_int_div_en <= filter_ctrl_active[FC_FIXED_INT];
            // Quarter turns land in the top two bits of the accumulator
            nco_phase_offset <= {filter_ctrl_active[FC_PHASE_HI:FC_PHASE_LO],
                                 {(PHASE_W-2){1'b0}}};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_enable_d       <= 1'b0;
            gain_slew_start   <= 1'b0;
            sample_phase_clear <= 1'b0;
        end else begin
            tx_enable_d       <= tx_enable;
            gain_slew_start   <= filter_ctrl_active[FC_GAIN_PROFILE]
                                 && (tx_enable != tx_enable_d);
            sample_phase_clear <= sample_freq_immediate_load
                                  && filter_ctrl_active[FC_CLEAR_PHASE];
        end
    end

    // ==========================================================
    // Checks
    a_pn_reset_gate: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (pseudo_noise_source_reset == $past(ch0_hardware_update_strobe && update_mask[MASK_PN])))
        else $error("noise source reset does not follow channel 0 strobe and mask");

    a_mask_allows_reload: assert property (@(posedge sys_clk) disable iff (rst)
        update_any && update_mask[MASK_GROUP_LO + GRP_GAIN] |=> slave_reload[GRP_GAIN])
        else $error("masked-in group did not reload on update");

    a_mask_blocks_reload: assert property (@(posedge sys_clk) disable iff (rst)
        (hardware_update_strobe || software_update_strobe) && !update_mask[MASK_GROUP_LO + GRP_FILTER_CTRL]
        && !immediate_update_en && $past(!immediate_update_en, 3) && $past(!immediate_update_en, 2)
        && $past(!immediate_update_en, 1)
        |=> !slave_reload[GRP_FILTER_CTRL])
        else $error("masked-out group reloaded on update");

    a_immediate_four_clk: assert property (@(posedge sys_clk) disable iff (rst)
        immediate_update_en && wr_filter |-> ##4 slave_reload[GRP_FILTER_CTRL]
        ##1 (filter_ctrl_active == $past(filter_ctrl)))
        else $error("immediate load not seen four clocks after write");

    a_fm_indication: assert property (@(posedge sys_clk) disable iff (rst)
        filter_ctrl_active[FC_FM_IND_DIS] |=> !internal_freq_mod_indication)
        else $error("FM indication passed while disabled");

    a_fm_q_fifo_off: assert property (@(posedge sys_clk) disable iff (rst)
        path_cfg.fm_mod_en |-> !path_cfg.q_fifo_en && !path_cfg.mod_invalid)
        else $error("Q FIFO in use during Internal_freq_mod_indication");

    a_fm_pre_i_only: assert property (@(posedge sys_clk) disable iff (rst)
        mod_type == MOD_FM_PRE |=> path_cfg.filter_before_fm && !path_cfg.q_filter_en)
        else $error("FM pre mode path wrong");

    a_interp_zero: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && filter_ctrl_active[FC_INTERP_HI:FC_INTERP_LO] == 2'h0
        |=> path_cfg.phase_zero && path_cfg.coarse_phases == PHASES_NONE)
        else $error("interpolation code 00 did not zero phase");

    a_phase_clear: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (sample_phase_clear == $past(sample_freq_immediate_load
                                         && filter_ctrl_active[FC_CLEAR_PHASE])))
        else $error("sample phase clear mismatch");

    a_gain_slew: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && $changed(tx_enable) && filter_ctrl_active[FC_GAIN_PROFILE] |=> gain_slew_start)
        else $error("gain slew missing on transmit enable change");

    a_mask_reserved: assert property (@(posedge sys_clk) disable iff (rst)
        host_req.rd && host_req.addr == ADDR_UPDATE_MASK |=> host_rdata[14:11] == 4'h0)
        else $error("reserved mask bits read non-zero");

    // Decode checks skip the release edge, where the outputs still hold reset
    a_gain_slew_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && !filter_ctrl_active[FC_GAIN_PROFILE] |=> !gain_slew_start)
        else $error("gain slew started with profiling off");

    a_fixed_int_follow: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (fixed_int_div_en == $past(filter_ctrl_active[FC_FIXED_INT])))
        else $error("fixed integer divider enable does not follow its bit");

    a_phase_offset_top: assert property (@(posedge sys_clk) disable iff (rst)
        !rst |=> nco_phase_offset[PHASE_W-3:0] == '0
        && nco_phase_offset[PHASE_W-1:PHASE_W-2] == $past(filter_ctrl_active[11:10]))
        else $error("phase offset not in quarter-turn steps");

    a_half_band_sel: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (path_cfg.half_band_en == $past(filter_ctrl_active[FC_HALF_BAND])))
        else $error("half-band selection does not follow its bit");

    a_coef_bank_sel: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (path_cfg.coef_bank_sel == $past(filter_ctrl_active[FC_COEF_SWITCH])))
        else $error("coefficient set does not follow its bit");

    a_mod_invalid_code: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && mod_type == MOD_INVALID |=> path_cfg.mod_invalid && !path_cfg.fm_mod_en)
        else $error("invalid modulation code not flagged");

    a_fm_post_both: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && mod_type == MOD_FM_POST |=> path_cfg.q_filter_en)
        else $error("FM post mode lost the Q shaping filter");

    a_interp_sixteen: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && filter_ctrl_active[FC_INTERP_HI:FC_INTERP_LO] == 2'h3
        |=> path_cfg.coarse_phases == PHASES_16 && !path_cfg.phase_zero)
        else $error("interpolation code 11 not sixteen phases");

    a_vector_path_order: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && mod_type == MOD_VECTOR |=> path_cfg.q_fifo_en && !path_cfg.fm_mod_en)
        else $error("vector mode path wrong");

    a_fm_post_order: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && mod_type == MOD_FM_POST |=> path_cfg.fm_before_filter
        && !path_cfg.filter_before_fm && path_cfg.fm_mod_en)
        else $error("FM post mode order wrong");

    a_fm_pre_order: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && mod_type == MOD_FM_PRE |=> path_cfg.fm_mod_en && !path_cfg.fm_before_filter)
        else $error("FM pre mode order wrong");

    a_active_copy_load: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && next_reload[GRP_FILTER_CTRL] |=> filter_ctrl_active == $past(filter_ctrl))
        else $error("filter control slave not loaded from master");

endmodule

/* tb/host_port_model.sv */
// Host processor model on the channel's 16-bit parallel register port.
// Assumes the registered read answer arrives one cycle after the read strobe.
`timescale 1ns/1ps

module host_port_model
    import chan_cfg_pkg::*;
(
    input  wire logic                    sys_clk,
    output chan_cfg_pkg::host_req_t      host_req,
    input  wire logic [chan_cfg_pkg::DATA_W-1:0] host_rdata,
    input  wire logic                    host_rvalid
);
    // ==========================================================
    // Bus cycles
    initial host_req = '0;

    // Idle bus shows the inverse of the last value so stale data never matches
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
        #1;
        d = host_rdata;
        ok = host_rvalid;
    endtask
endmodule

/* tb/channel_filter_control_update_mask_tb.sv */
// Self-checking bench for the channel filter control and update mask block.
// Assumes the host model drives the register port; strobes are driven here.
`timescale 1ns/1ps

module channel_filter_control_update_mask_tb;
    import chan_cfg_pkg::*;

    // ==========================================================
    // Clock, stimulus and wiring
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    logic [3:0]       ev = 4'h0;
    logic [4:0]       mw = 5'h00;
    logic             imm_en = 1'b0;
    logic             tx_enable = 1'b0;
    host_req_t        host_req;
    logic [15:0]      host_rdata;
    logic             host_rvalid;
    logic [4:0]       slave_reload;
    logic             pn_reset;
    logic             gain_slew_start;
    logic             sample_phase_clear;
    logic             fm_ind;
    logic             fixed_int_div_en;
    logic [31:0]      nco_phase_offset;
    path_cfg_t        path_cfg;
    int               failures = 0;
    int               checks_done = 0;
    logic [15:0]      fc;
    logic [15:0]      fc_tab [4] = '{16'h2030, 16'h3F45, 16'h04FA, 16'h28BF};

    always #2.5 sys_clk = ~sys_clk;

    host_port_model i_host (
        .sys_clk     (sys_clk),
        .host_req    (host_req),
        .host_rdata  (host_rdata),
        .host_rvalid (host_rvalid)
    );

    channel_filter_control_update_mask #(.PHASE_W(32)) i_dut (
        .sys_clk                      (sys_clk),
        .rst                          (rst),
        .host_req                     (host_req),
        .hardware_update_strobe       (ev[2]),
        .ch0_hardware_update_strobe   (ev[3]),
        .software_update_strobe       (ev[1]),
        .immediate_update_en          (imm_en),
        .master_written               (mw),
        .sample_freq_immediate_load   (ev[0]),
        .tx_enable                    (tx_enable),
        .host_rdata                   (host_rdata),
        .host_rvalid                  (host_rvalid),
        .slave_reload                 (slave_reload),
        .pseudo_noise_source_reset    (pn_reset),
        .gain_slew_start              (gain_slew_start),
        .sample_phase_clear           (sample_phase_clear),
        .internal_freq_mod_indication (fm_ind),
        .fixed_int_div_en             (fixed_int_div_en),
        .nco_phase_offset             (nco_phase_offset),
        .path_cfg                     (path_cfg)
    );

    // ==========================================================
    // Compare, drive and closing tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_path(input path_cfg_t got, input path_cfg_t exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        i_host.read_reg(a, d, ok);
        check_val({31'h0, ok}, 32'h1);
        check_val({16'h0, d}, {16'h0, e});
    endtask

    // Events are {ch0 strobe, hw strobe, sw strobe, sample freq load}
    task automatic pulse_ev(input logic [3:0] e);
        @(posedge sys_clk);
        ev <= e;
        @(posedge sys_clk);
        ev <= 4'h0;
        #1;
    endtask

    task automatic stop_test;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic path_cfg_t exp_path(input logic [15:0] f);
        path_cfg_t p;
        p = '0;
        case (f[3:2])
            2'b00: {p.q_filter_en, p.q_fifo_en} = 2'b11;
            2'b01: {p.fm_mod_en, p.fm_before_filter, p.q_filter_en} = 3'b111;
            2'b10: {p.fm_mod_en, p.filter_before_fm} = 2'b11;
            default: p.mod_invalid = 1'b1;
        endcase
        p.half_band_en = f[9];
        p.coef_bank_sel = f[8];
        p.span_taps = {1'b0, f[7:4]} + 5'h01;
        p.coarse_phases = (f[1:0] == 2'b00) ? 5'h00 : (5'h02 << f[1:0]);
        p.phase_zero = (f[1:0] == 2'b00);
        return p;
    endfunction

    // ==========================================================
    // Tests
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(ADDR_FILTER_CTRL, 16'h0000);
        rd_chk(ADDR_UPDATE_MASK, 16'h0000);
        rd_chk(8'h20, 16'h0000);
        check_path(path_cfg, exp_path(16'h0000));
        i_host.write_reg(ADDR_UPDATE_MASK, 16'hFFFF);
        rd_chk(ADDR_UPDATE_MASK, 16'h87C0);
        pulse_ev(4'b0100);
        check_val({27'h0, slave_reload}, 32'h1F);
        for (int g = 0; g < 5; g++) begin
            i_host.write_reg(ADDR_UPDATE_MASK, 16'h0040 << g);
            pulse_ev(g[0] ? 4'b0010 : 4'b0100);
            check_val({27'h0, slave_reload}, 32'h1 << g);
        end
        i_host.write_reg(ADDR_UPDATE_MASK, 16'h0000);
        pulse_ev(4'b0110);
        check_val({27'h0, slave_reload}, 32'h0);
        for (int i = 0; i < 2; i++) begin
            i_host.write_reg(ADDR_UPDATE_MASK, (i == 0) ? 16'h8000 : 16'h7FFF);
            pulse_ev(4'b1000);
            check_val({31'h0, pn_reset}, (i == 0) ? 32'h1 : 32'h0);
        end
        i_host.write_reg(ADDR_UPDATE_MASK, 16'h0200);
        foreach (fc_tab[i]) begin
            fc = fc_tab[i];
            i_host.write_reg(ADDR_FILTER_CTRL, fc);
            rd_chk(ADDR_FILTER_CTRL, fc);
            pulse_ev(4'b0010);
            check_val({27'h0, slave_reload}, 32'h08);
            @(posedge sys_clk);
            #1;
            check_path(path_cfg, exp_path(fc));
            check_val({31'h0, fixed_int_div_en}, {31'h0, fc[12]});
            check_val(nco_phase_offset, {fc[11:10], 30'h0});
            check_val({31'h0, fm_ind}, {31'h0, (fc[3] ^ fc[2]) & ~fc[13]});
        end
        // Gain slew and phase clear follow the active copy, so reload first
        for (int i = 0; i < 2; i++) begin
            fc = (i == 0) ? 16'hC000 : 16'h0000;
            i_host.write_reg(ADDR_FILTER_CTRL, fc);
            pulse_ev(4'b0010);
            @(posedge sys_clk);
            tx_enable <= ~tx_enable;
            @(posedge sys_clk);
            #1;
            check_val({31'h0, gain_slew_start}, {31'h0, fc[15]});
            pulse_ev(4'b0001);
            check_val({31'h0, sample_phase_clear}, {31'h0, fc[14]});
        end
        i_host.write_reg(ADDR_UPDATE_MASK, 16'h0000);
        @(posedge sys_clk);
        imm_en <= 1'b1;
        mw <= 5'h02;
        @(posedge sys_clk);
        mw <= 5'h00;
        repeat (3) @(posedge sys_clk);
        #1;
        check_val({27'h0, slave_reload}, 32'h02);
        // Filter write with the mask shut still reloads through the bypass
        fc = 16'h0A45;
        i_host.write_reg(ADDR_FILTER_CTRL, fc);
        repeat (3) @(posedge sys_clk);
        #1;
        check_val({27'h0, slave_reload}, 32'h08);
        @(posedge sys_clk);
        #1;
        check_path(path_cfg, exp_path(fc));
        stop_test();
    end
endmodule
